//--- design/mrds_regs.svh
// timing, loop and acquisition constants for the read data separator
`ifndef MRDS_REGS_SVH
`define MRDS_REGS_SVH

`define MRDS_CLK_NS      10
`define MRDS_SHAPE_NS    60
`define MRDS_SHAPE_CYC   ((`MRDS_SHAPE_NS + `MRDS_CLK_NS - 1) / `MRDS_CLK_NS)
`define MRDS_OSC_KHZ     8200
`define MRDS_CLK_KHZ     100000
`define MRDS_OSC_INC     ((`MRDS_OSC_KHZ * 65536 + `MRDS_CLK_KHZ / 2) / `MRDS_CLK_KHZ)
`define MRDS_ACQ_BYTES   4
`define MRDS_ACQ_OSC     (`MRDS_ACQ_BYTES * 8 * 2)
`define MRDS_ERR_SHIFT   12
`define MRDS_GAIN_FAST   16
`define MRDS_GAIN_TRACK  1
`define MRDS_PROP_FAST   512
`define MRDS_PROP_TRACK  96
`define MRDS_FREQ_SHIFT  4

`endif

//--- design/mrds_pkg.sv
// types for the read data separator
package mrds_pkg;

  typedef enum logic [2:0] {
    ACQ_IDLE  = 3'b001,
    ACQ_FAST  = 3'b010,
    ACQ_TRACK = 3'b100
  } mrds_acq_t;

endpackage

//--- design/mrds_pulse_if.sv
// carrier between the separator core and its pulse shaper
`timescale 1ns/1ps
interface mrds_pulse_if;
  logic evt;
  logic shaped;
  logic lead;
  modport src (output evt, input shaped, input lead);
  modport shp (input evt, output shaped, output lead);
endinterface

//--- design/mrds_pulse_shaper.sv
// stretches each pulse event that finds the shaper idle to a fixed width
`timescale 1ns/1ps
`include "mrds_regs.svh"
module mrds_pulse_shaper (
  input  wire logic  clock,
  input  wire logic  resetn,
  mrds_pulse_if.shp  pif
);

  localparam logic [3:0] SHAPE_CYC = 4'(`MRDS_SHAPE_CYC);

  logic [3:0] width_reg;
  logic       lead_reg;

  // count down the shaped width, reload on a new event only once it has run out
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      width_reg <= 4'h0;
      lead_reg  <= 1'b0;
    end else begin
      lead_reg <= pif.evt && (width_reg == 4'h0);
      if (pif.evt && (width_reg == 4'h0)) begin
        width_reg <= SHAPE_CYC; // see R3
      end else if (width_reg != 4'h0) begin
        width_reg <= width_reg - 4'h1;
      end
    end
  end

  assign pif.shaped = (width_reg != 4'h0);
  assign pif.lead   = lead_reg;

endmodule

//--- design/mrds_separator.sv
// read data separator: loop, acquisition control and window logic
// Notes on behaviour
// R1 - decode pulse stream to nrz plus clock
// R2 - loopback write pulses during maintenance
// R3 - reshape each pulse to fixed width
// R4 - oscillator locks at twice bit rate
// R5 - compare pulse against inverted oscillator
// R6 - speed-up or slow-down pulse, error-long
// R7 - slow integrator tracks drift, ignores jitter
// R8 - loop settles within four byte times
// R9 - preamble enters loop only when gated
// R10 - fast acquire on zero preamble bytes
// R11 - separator enabled after fast acquire done
// R12 - enable flop sets on first pulse
// R13 - window flop toggles, true output clocks
// R14 - window set means ones, else zeros
// R15 - data flop sets on one in window
// R16 - window gate transfers and clears data
// R17 - source puts pulses per mfm coding
// R18 - initialize clears flops and fast acquire
`timescale 1ns/1ps
`include "mrds_regs.svh"
module mrds_separator (
  input  wire logic  clock,
  input  wire logic  resetn,
  input  wire logic  link_clock,
  input  wire logic  disk_read_pulses_n,
  input  wire logic  write_loop_pulses_n,
  input  wire logic  maint_active,
  input  wire logic  read_header,
  input  wire logic  sector_sync_pulse,
  input  wire logic  drive_ctl_gate,
  input  wire logic  lock_gate_enable,
  input  wire logic  ctl_init,
  output logic       recovered_osc,
  output logic       speed_up,
  output logic       slow_down,
  output logic       rapid_acquire,
  output logic       separator_enable,
  output logic       separator_clock_true,
  output logic       separator_clock_comp,
  output logic       separated_nrz
);

  localparam logic [15:0] OSC_INC    = 16'(`MRDS_OSC_INC);
  localparam logic [6:0]  ACQ_OSC    = 7'(`MRDS_ACQ_OSC);
  localparam logic [19:0] GAIN_FAST  = 20'(`MRDS_GAIN_FAST);
  localparam logic [19:0] GAIN_TRACK = 20'(`MRDS_GAIN_TRACK);
  localparam logic [15:0] PROP_FAST  = 16'(`MRDS_PROP_FAST);
  localparam logic [15:0] PROP_TRACK = 16'(`MRDS_PROP_TRACK);

  // ---------------- link domain: pulse capture ----------------
  logic disk_meta_reg;
  logic disk_sync_reg;
  logic wr_meta_reg;
  logic wr_sync_reg;
  logic maint_meta_reg;
  logic maint_sync_reg;
  logic src_prev_reg;
  logic pulse_tgl_reg;
  wire  src_n;
  wire  src_fall;

  // source select: loopback while maintenance runs
  assign src_n    = maint_sync_reg ? wr_sync_reg : disk_sync_reg; // see R2
  assign src_fall = src_prev_reg && !src_n;

  // two-flop synchronisers on the pins and on the select level
  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn) begin
      disk_meta_reg  <= 1'b1;
      disk_sync_reg  <= 1'b1;
      wr_meta_reg    <= 1'b1;
      wr_sync_reg    <= 1'b1;
      maint_meta_reg <= 1'b0;
      maint_sync_reg <= 1'b0;
    end else begin
      disk_meta_reg  <= disk_read_pulses_n;
      disk_sync_reg  <= disk_meta_reg;
      wr_meta_reg    <= write_loop_pulses_n;
      wr_sync_reg    <= wr_meta_reg;
      maint_meta_reg <= maint_active;
      maint_sync_reg <= maint_meta_reg;
    end
  end

  // each leading edge flips a toggle that crosses to the core
  always_ff @(posedge link_clock or negedge resetn) begin
    if (!resetn) begin
      src_prev_reg  <= 1'b1;
      pulse_tgl_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_n;
      if (src_fall) begin
        pulse_tgl_reg <= !pulse_tgl_reg;
      end
    end
  end

  // ---------------- core domain ----------------
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_prev_reg;

  // toggle crossing back into the core clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_prev_reg <= 1'b0;
    end else begin
      tgl_meta_reg <= pulse_tgl_reg;
      tgl_sync_reg <= tgl_meta_reg;
      tgl_prev_reg <= tgl_sync_reg;
    end
  end

  mrds_pulse_if pif ();

  assign pif.evt = tgl_sync_reg ^ tgl_prev_reg;

  mrds_pulse_shaper u_shaper (
    .clock  (clock),
    .resetn (resetn),
    .pif    (pif)
  );

  // ---------------- loop gating ----------------
  logic sync_seen_reg;
  wire  loop_gate;
  wire  loop_pulse;

  // header preamble is let in only after sync and with both gates
  assign loop_gate  = drive_ctl_gate && lock_gate_enable
                      && (!read_header || sync_seen_reg); // see R9
  assign loop_pulse = pif.lead && loop_gate;

  // remember the sector sync for the header read; a sync beats init
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync_seen_reg <= 1'b0;
    end else if (!read_header || (ctl_init && !sector_sync_pulse)) begin
      sync_seen_reg <= 1'b0;
    end else if (sector_sync_pulse) begin
      sync_seen_reg <= 1'b1;
    end
  end

  // ---------------- oscillator and phase comparator ----------------
  logic [15:0]        phase_reg;
  logic [15:0]        phase_next;
  logic signed [19:0] freq_acc_reg;
  logic [3:0]         up_cnt_reg;
  logic [3:0]         dn_cnt_reg;
  logic               osc_prev_reg;
  logic               fast_mode;
  wire  [15:0]        err_mag;
  wire  [3:0]         err_cyc;
  wire  [15:0]        freq_trim;
  wire  [15:0]        prop;
  wire  [15:0]        inc;
  wire                osc_rise;

  // error against the inverted oscillator edge at phase zero
  assign err_mag  = phase_reg[15] ? (16'h0 - phase_reg) : phase_reg; // see R5
  assign err_cyc  = err_mag[`MRDS_ERR_SHIFT+3:`MRDS_ERR_SHIFT] | 4'h1;
  assign freq_trim = 16'(freq_acc_reg >>> `MRDS_FREQ_SHIFT);
  assign prop      = fast_mode ? PROP_FAST : PROP_TRACK;
  // step: nominal plus integrated trim plus proportional nudge
  assign inc = OSC_INC + freq_trim
               + ((up_cnt_reg != 4'h0) ? prop : 16'h0)
               - ((dn_cnt_reg != 4'h0) ? prop : 16'h0); // see R4
  assign phase_next = phase_reg + inc;
  assign osc_rise   = phase_next[15] && !osc_prev_reg;

  // numerically controlled oscillator at twice the bit rate
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_reg    <= 16'h0000;
      osc_prev_reg <= 1'b0;
    end else begin
      phase_reg    <= phase_next; // see R4
      osc_prev_reg <= phase_next[15];
    end
  end

  // speed-up or slow-down pulse as long as the phase error
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      up_cnt_reg <= 4'h0;
      dn_cnt_reg <= 4'h0;
    end else if (ctl_init) begin
      up_cnt_reg <= 4'h0;
      dn_cnt_reg <= 4'h0;
    end else if (loop_pulse) begin
      // oscillator lagging: phase below zero, speed it up
      up_cnt_reg <= phase_reg[15] ? err_cyc : 4'h0; // see R6
      dn_cnt_reg <= phase_reg[15] ? 4'h0 : err_cyc; // see R6
    end else begin
      if (up_cnt_reg != 4'h0) begin
        up_cnt_reg <= up_cnt_reg - 4'h1;
      end
      if (dn_cnt_reg != 4'h0) begin
        dn_cnt_reg <= dn_cnt_reg - 4'h1;
      end
    end
  end

  // integrator: area of the error pulses, small gain when tracking
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      freq_acc_reg <= 20'sh0;
    end else if (up_cnt_reg != 4'h0) begin
      freq_acc_reg <= freq_acc_reg + (fast_mode ? GAIN_FAST : GAIN_TRACK); // see R7
    end else if (dn_cnt_reg != 4'h0) begin
      freq_acc_reg <= freq_acc_reg - (fast_mode ? GAIN_FAST : GAIN_TRACK); // see R7
    end
  end

  // ---------------- acquisition control ----------------
  mrds_pkg::mrds_acq_t acq_reg;
  mrds_pkg::mrds_acq_t acq_next;
  logic [6:0]          acq_cnt_reg;
  wire                 acq_done;

  assign acq_done = (acq_cnt_reg == ACQ_OSC - 7'h1) && osc_rise; // see R8

  // idle, fast acquire over the preamble, then tracking
  always_comb begin
    acq_next = acq_reg;
    case (acq_reg)
      mrds_pkg::ACQ_IDLE: begin
        if (loop_gate && loop_pulse) begin
          acq_next = mrds_pkg::ACQ_FAST; // see R10
        end
      end
      mrds_pkg::ACQ_FAST: begin
        if (!loop_gate) begin
          acq_next = mrds_pkg::ACQ_IDLE;
        end else if (acq_done) begin
          acq_next = mrds_pkg::ACQ_TRACK; // see R11
        end
      end
      mrds_pkg::ACQ_TRACK: begin
        if (!loop_gate) begin
          acq_next = mrds_pkg::ACQ_IDLE;
        end
      end
      default: begin
        acq_next = mrds_pkg::ACQ_IDLE;
      end
    endcase
    if (ctl_init) begin
      acq_next = mrds_pkg::ACQ_IDLE; // see R18
    end
  end

  // state and oscillator-cycle count for the preamble
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      acq_reg     <= mrds_pkg::ACQ_IDLE;
      acq_cnt_reg <= 7'h00;
    end else begin
      acq_reg <= acq_next;
      if (acq_reg != mrds_pkg::ACQ_FAST) begin
        acq_cnt_reg <= 7'h00;
      end else if (osc_rise) begin
        acq_cnt_reg <= acq_cnt_reg + 7'h1;
      end
    end
  end

  // ---------------- separator ----------------
  logic sep_en_reg;
  logic enable_reg;
  logic window_reg;
  logic data_reg;
  logic nrz_reg;
  wire  sep_en_next;
  wire  one_pulse;
  wire  window_gate;

  // rapid acquire is the enable flop's reset side during the preamble
  assign fast_mode   = (acq_reg == mrds_pkg::ACQ_FAST) && !enable_reg; // see R10
  assign sep_en_next = (acq_reg == mrds_pkg::ACQ_TRACK) && !ctl_init; // see R11
  // a pulse inside a set window is a cell-centre one
  assign one_pulse   = pif.lead && window_reg && enable_reg; // see R14
  // window gate at the close of each set window
  assign window_gate = enable_reg && window_reg && osc_rise; // see R16

  // separator enable follows the end of fast acquisition
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sep_en_reg <= 1'b0;
    end else begin
      sep_en_reg <= sep_en_next; // see R11
    end
  end

  // enable flop: first pulse after enable, held until enable drops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_reg <= 1'b0;
    end else if (ctl_init || !sep_en_reg) begin
      enable_reg <= 1'b0; // see R18
    end else if (pif.lead) begin
      enable_reg <= 1'b1; // see R12
    end
  end

  // window flop toggles on each oscillator rise once enabled
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      window_reg <= 1'b0;
    end else if (ctl_init || !enable_reg) begin
      window_reg <= 1'b0; // see R18
    end else if (osc_rise) begin
      window_reg <= !window_reg; // see R13
    end
  end

  // data flop: set by a one, cleared by the gate; set wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      data_reg <= 1'b0;
    end else if (ctl_init) begin
      data_reg <= 1'b0; // see R18
    end else if (one_pulse) begin
      data_reg <= 1'b1; // see R15
    end else if (window_gate) begin
      data_reg <= 1'b0; // see R16
    end
  end

  // separated data flop loads on the window gate
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      nrz_reg <= 1'b0;
    end else if (ctl_init || !enable_reg) begin
      nrz_reg <= 1'b0; // see R18
    end else if (window_gate) begin
      nrz_reg <= data_reg || one_pulse; // see R16
    end
  end

  // ---------------- registered outputs ----------------
  // every output straight from a flop; clock and data stay aligned
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      recovered_osc        <= 1'b0;
      speed_up             <= 1'b0;
      slow_down            <= 1'b0;
      rapid_acquire        <= 1'b0;
      separator_enable     <= 1'b0;
      separator_clock_true <= 1'b0;
      separator_clock_comp <= 1'b1;
      separated_nrz        <= 1'b0;
    end else begin
      recovered_osc        <= phase_reg[15];
      speed_up             <= (up_cnt_reg != 4'h0); // see R6
      slow_down            <= (dn_cnt_reg != 4'h0); // see R6
      rapid_acquire        <= fast_mode; // see R10
      separator_enable     <= sep_en_reg;
      separator_clock_true <= window_reg; // see R13
      separator_clock_comp <= !window_reg; // see R13
      separated_nrz        <= nrz_reg; // see R1
    end
  end

endmodule

//--- test/mrds_sep_monitor.sv
// port checker for the read data separator
`timescale 1ns/1ps
module mrds_sep_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic link_clock,
  input wire logic disk_read_pulses_n,
  input wire logic write_loop_pulses_n,
  input wire logic maint_active,
  input wire logic read_header,
  input wire logic sector_sync_pulse,
  input wire logic drive_ctl_gate,
  input wire logic lock_gate_enable,
  input wire logic ctl_init,
  input wire logic recovered_osc,
  input wire logic speed_up,
  input wire logic slow_down,
  input wire logic rapid_acquire,
  input wire logic separator_enable,
  input wire logic separator_clock_true,
  input wire logic separator_clock_comp,
  input wire logic separated_nrz
);
  logic [4:0] up_run;
  logic [4:0] osc_run;
  logic [9:0] acq_run;

  // run lengths of speed-up correction, oscillator level and fast acquire
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      up_run  <= 5'h00;
      osc_run <= 5'h00;
      acq_run <= 10'h000;
    end else begin
      up_run  <= speed_up ? up_run + 5'h01 : 5'h00;
      osc_run <= $stable(recovered_osc) ? osc_run + 5'h01 : 5'h00;
      acq_run <= rapid_acquire ? acq_run + 10'h001 : 10'h000;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // a gate lost, then the separator falls back to idle
  sequence gate_lost;
    !drive_ctl_gate || !lock_gate_enable;
  endsequence
  sequence settles_idle;
    ##[1:3] (!rapid_acquire && !separator_enable);
  endsequence

  chk_clock_pair: assert property (separator_clock_comp == !separator_clock_true)
    else $error("separator clock outputs not complementary");
  chk_corr_excl: assert property (!(speed_up && slow_down))
    else $error("speed-up and slow-down together");
  chk_corr_len: assert property (up_run <= 5'h0F)
    else $error("speed-up pulse too long");
  chk_osc_half: assert property (osc_run <= 5'h0A)
    else $error("oscillator half period too long");
  chk_acq_bound: assert property (acq_run <= 10'h384)
    else $error("fast acquire did not finish");
  chk_enable_after: assert property (separator_enable |-> !rapid_acquire)
    else $error("separator enabled during fast acquire");
  chk_acq_gated: assert property (
    $rose(rapid_acquire) |-> $past(drive_ctl_gate) && $past(lock_gate_enable))
    else $error("fast acquire started with gates closed");
  chk_gate_idle: assert property (gate_lost [*2] |-> settles_idle)
    else $error("separator active after gate drop");
  chk_init_clear: assert property (
    ctl_init [*3] |-> !rapid_acquire && !separator_enable && !separated_nrz
                      && !separator_clock_true)
    else $error("initialize left state set");
  chk_nrz_enabled: assert property (
    $rose(separated_nrz) |-> separator_enable || $past(separator_enable))
    else $error("data one while separator disabled");
endmodule

bind mrds_separator mrds_sep_monitor i_mon (
  .clock(clock), .resetn(resetn), .link_clock(link_clock),
  .disk_read_pulses_n(disk_read_pulses_n), .write_loop_pulses_n(write_loop_pulses_n),
  .maint_active(maint_active), .read_header(read_header),
  .sector_sync_pulse(sector_sync_pulse), .drive_ctl_gate(drive_ctl_gate),
  .lock_gate_enable(lock_gate_enable), .ctl_init(ctl_init), .recovered_osc(recovered_osc),
  .speed_up(speed_up), .slow_down(slow_down), .rapid_acquire(rapid_acquire),
  .separator_enable(separator_enable), .separator_clock_true(separator_clock_true),
  .separator_clock_comp(separator_clock_comp), .separated_nrz(separated_nrz)
);

//--- test/mrds_drive_model.sv
// behavioural read channel sending a repeating byte as mfm pulses
`timescale 1ns/1ps
module mrds_drive_model #(
  parameter real HALF_NS = 122.0
) (
  input  wire logic       send,
  input  wire logic [7:0] pattern,
  output logic            pulses_n
);
  logic prev_bit;

  // one half cell, low for 60 ns when a flux reversal is due
  task automatic half_cell(input logic flux);
    pulses_n = !flux;
    #60;
    pulses_n = 1'b1;
    #(HALF_NS - 60.0);
  endtask

  // line rests at its pull-up level outside frames
  initial begin
    pulses_n = 1'b1;
    prev_bit = 1'b1;
    forever begin
      if (send !== 1'b1) begin
        prev_bit = 1'b1;
        #(HALF_NS);
      end else begin
        for (int i = 7; i >= 0; i--) begin
          half_cell(!pattern[i] && !prev_bit);
          half_cell(pattern[i]);
          prev_bit = pattern[i];
        end
      end
    end
  end
endmodule

//--- test/tb.sv
// self-checking bench for the read data separator
`timescale 1ns/1ps
module tb;
  logic       clock, resetn, link_clock, disk_n, loop_n, maint_active, read_header;
  logic       sector_sync_pulse, drive_ctl_gate, lock_gate_enable, ctl_init;
  logic       disk_send, loop_send, osc, up, down, rapid, sep_en, ds_clk, ds_clk_n, nrz;
  logic [7:0] disk_pat, loop_pat;
  int         err_total, comparisons, cycles, n_corr;

  mrds_separator i_dut (
    .clock(clock), .resetn(resetn), .link_clock(link_clock),
    .disk_read_pulses_n(disk_n), .write_loop_pulses_n(loop_n),
    .maint_active(maint_active), .read_header(read_header),
    .sector_sync_pulse(sector_sync_pulse), .drive_ctl_gate(drive_ctl_gate),
    .lock_gate_enable(lock_gate_enable), .ctl_init(ctl_init), .recovered_osc(osc),
    .speed_up(up), .slow_down(down), .rapid_acquire(rapid), .separator_enable(sep_en),
    .separator_clock_true(ds_clk), .separator_clock_comp(ds_clk_n), .separated_nrz(nrz));
  mrds_drive_model #(.HALF_NS(122.0)) i_disk (.send(disk_send), .pattern(disk_pat),
    .pulses_n(disk_n));
  mrds_drive_model #(.HALF_NS(120.0)) i_loop (.send(loop_send), .pattern(loop_pat),
    .pulses_n(loop_n));

  // core clock and an unrelated link clock
  always #5 clock = ~clock;
  initial begin
    link_clock = 1'b0;
    #7;
    forever #24 link_clock = ~link_clock;
  end

  // loop correction activity, sampled away from the launching edge
  always @(negedge clock) begin
    if (up || down) n_corr++;
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  // bounded wait for rapid (sel 0) or sep_en (sel 1) to reach want
  task automatic await(input int sel, input logic want, input int lim, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clock);
      #1;
      hit = (((sel == 0) ? rapid : sep_en) === want);
    end
  endtask

  // counts ones of nrz across n separator clock periods
  task automatic read_bits(input int n, output int ones);
    ones = 0;
    for (int i = 0; i < n; i++) begin
      @(posedge ds_clk);
      #1;
      if (nrz === 1'b1) ones++;
    end
  endtask

  task automatic t_reset();
    repeat (3) @(posedge clock);
    #1;
    check(16'({rapid, sep_en, nrz, ds_clk, ds_clk_n}), 16'h0001, "reset outputs");
    @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge link_clock);
  endtask

  task automatic t_lock_decode();
    logic   hit;
    int     ones;
    longint t0;
    @(posedge clock);
    disk_send <= 1'b1;
    drive_ctl_gate <= 1'b1;
    lock_gate_enable <= 1'b1;
    await(0, 1'b1, 400, hit);
    check(16'(hit), 16'h0001, "fast acquire start");
    await(0, 1'b0, 1000, hit);
    check(16'(hit), 16'h0001, "fast acquire end");
    await(1, 1'b1, 10, hit);
    check(16'(hit), 16'h0001, "separator enable");
    @(posedge ds_clk);
    t0 = $time;
    @(posedge ds_clk);
    check(16'(($time - t0) >= 220 && ($time - t0) <= 270), 16'h0001, "window period");
    @(posedge osc);
    t0 = $time;
    @(posedge osc);
    check(16'(($time - t0) >= 100 && ($time - t0) <= 140), 16'h0001, "osc period");
    disk_pat <= 8'hFF;
    read_bits(8, ones);
    read_bits(16, ones);
    check(16'(ones), 16'h0010, "ones decoded");
    disk_pat <= 8'h00;
    read_bits(4, ones);
    read_bits(16, ones);
    check(16'(ones), 16'h0000, "zeros decoded");
    check(16'(n_corr > 0), 16'h0001, "loop corrections seen");
  endtask

  task automatic t_gate_drop();
    @(posedge clock);
    lock_gate_enable <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    check(16'({rapid, sep_en}), 16'h0000, "gate drop idle");
  endtask

  task automatic t_header();
    logic hit;
    @(posedge clock);
    read_header <= 1'b1;
    lock_gate_enable <= 1'b1;
    repeat (300) @(posedge clock);
    #1;
    check(16'(rapid), 16'h0000, "header waits for sync");
    @(posedge clock);
    sector_sync_pulse <= 1'b1;
    @(posedge clock);
    sector_sync_pulse <= 1'b0;
    await(0, 1'b1, 400, hit);
    check(16'(hit), 16'h0001, "header acquire after sync");
  endtask

  task automatic t_init_maint();
    logic hit;
    @(posedge clock);
    ctl_init <= 1'b1;
    read_header <= 1'b0;
    maint_active <= 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(16'({rapid, sep_en, nrz, ds_clk}), 16'h0000, "initialize clears");
    // hold init until the loopback select has crossed and disk pulses have drained
    repeat (30) @(posedge clock);
    ctl_init <= 1'b0;
    repeat (400) @(posedge clock);
    #1;
    check(16'(rapid), 16'h0000, "disk pulses ignored in loopback");
    @(posedge clock);
    loop_send <= 1'b1;
    await(0, 1'b1, 400, hit);
    check(16'(hit), 16'h0001, "loopback acquire");
    await(1, 1'b1, 1200, hit);
    check(16'(hit), 16'h0001, "loopback enable");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    {maint_active, read_header, sector_sync_pulse, drive_ctl_gate} = 4'h0;
    {lock_gate_enable, ctl_init, disk_send, loop_send} = 4'h0;
    disk_pat = 8'h00;
    loop_pat = 8'h00;
    {err_total, comparisons, cycles, n_corr} = {32'h0, 32'h0, 32'h0, 32'h0};
    t_reset();
    t_lock_decode();
    t_gate_drop();
    t_header();
    t_init_maint();
    end_of_test();
  end
endmodule
